// >>> bench/pmw_core_model.sv
// Purpose: core side issuing power-down and watchdog clear strobes
// Assumes: strobes change on the falling edge and last one cycle
// Notes: the bench calls the tasks only while the core runs
`timescale 1ns/1ns
`default_nettype none
module pmw_core_model (
  input wire logic clk,
  output logic halt_exec,
  output logic wdt_clear_exec
);
  initial begin
    halt_exec = 1'h0;
    wdt_clear_exec = 1'h0;
  end
  task automatic do_halt;
    @(negedge clk) halt_exec = 1'h1;
    @(negedge clk) halt_exec = 1'h0;
  endtask
  task automatic do_clear;
    @(negedge clk) wdt_clear_exec = 1'h1;
    @(negedge clk) wdt_clear_exec = 1'h0;
  endtask
endmodule
`default_nettype wire

// >>> bench/pmw_ctrl_asserts.sv
// Purpose: port-level checks of the mode and wake-up controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes: start-up and reset delay counts are judged by the bench
`timescale 1ns/1ns
`default_nettype none
module pmw_ctrl_asserts (
  input wire logic clk, rst_n, halt_exec, lowspeed_xtal_keepalive, slow_clock_sel,
  input wire logic cfg_lowspeed_rc_osc_enable, xtal_power_wr, xtal_power_wdata, hs_clk_en,
  input wire logic ls_clk_en, lowspeed_rc_osc_en, core_run, power_down_flag, timeout_flag,
  input wire logic wdt_clear, lowspeed_xtal_power_sel, wdt_enabled,
  input wire logic [2:0] op_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic halt_ok = halt_exec && op_mode == 3'h0;
  property p_sleep; halt_ok && !lowspeed_xtal_keepalive |=> op_mode == 3'h2 && !ls_clk_en; endproperty
  a_sleep: assert property (p_sleep) else $error("halt missed sleep");
  property p_idle; halt_ok && lowspeed_xtal_keepalive |=> op_mode == 3'h1 && ls_clk_en; endproperty
  a_idle: assert property (p_idle) else $error("halt missed idle");
  property p_flags; halt_ok |=> power_down_flag && !timeout_flag; endproperty
  a_flags: assert property (p_flags) else $error("flags wrong after halt");
  // a disabled watchdog takes no clear, so the halt clear only fires when it is enabled
  property p_wdclr; halt_ok && !lowspeed_xtal_keepalive |=> wdt_clear == $past(wdt_enabled);
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("no watchdog clear");
  property p_hsoff; op_mode inside {3'h1, 3'h2} |-> !hs_clk_en && !core_run; endproperty
  a_hsoff: assert property (p_hsoff) else $error("fast clock or core live");
  property p_lowspeed_rc_osc; op_mode inside {3'h1, 3'h2} && cfg_lowspeed_rc_osc_enable |-> lowspeed_rc_osc_en; endproperty
  a_lowspeed_rc_osc: assert property (p_lowspeed_rc_osc) else $error("rc stopped in power-down");
  // register lag: the fast clock enable follows the select sampled one edge earlier
  property p_norm; op_mode == 3'h0 && $past(op_mode) == 3'h0 && $past(core_run)
    |-> hs_clk_en == !$past(slow_clock_sel) && ls_clk_en; endproperty
  a_norm: assert property (p_norm) else $error("clock source wrong");
  property p_psel; xtal_power_wr |=> lowspeed_xtal_power_sel == $past(xtal_power_wdata); endproperty
  a_psel: assert property (p_psel) else $error("power select not written");
  property p_hold; op_mode == 3'h2 && $past(op_mode) == 3'h2
    |-> $stable(power_down_flag) && $stable(timeout_flag); endproperty
  a_hold: assert property (p_hold) else $error("flags moved in sleep");
endmodule
bind pmw_ctrl pmw_ctrl_asserts chk_u (.*);
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the mode and wake-up controller
// Assumes: reset delay shortened to 10 cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pmw_pkg::*;
  localparam int unsigned RDLY = 10;
  logic clk = 1'h0, rst_n = 1'h0, ext_reset_n_pin = 1'h1, xtal_power_wr = 1'h0;
  logic xtal_power_wdata = 1'h0, slow_clock_sel = 1'h0, lowspeed_xtal_keepalive = 1'h0;
  logic cfg_wdt_enable = 1'h0, cfg_lowspeed_rc_osc_enable = 1'h1, cfg_wdt_on_lowspeed_rc_osc = 1'h1;
  logic cfg_osc_is_crystal = 1'h0, cfg_rc_short_start = 1'h1, wdt_overflow = 1'h0;
  logic irq_request = 1'h0, irq_enabled = 1'h0, stack_full = 1'h0;
  logic [7:0] port_a_pins = 8'hff, port_a_wake_select = 8'h80;
  logic [3:0] watchdog_enable_field = 4'ha;
  logic halt_exec, wdt_clear_exec, hs_clk_en, ls_clk_en, sys_on_slow, lowspeed_rc_osc_en;
  logic lowspeed_xtal_power_sel, core_run, power_down_flag, timeout_flag;
  logic wdt_clear, wdt_enabled, full_reset;
  pmw_resume_s resume;
  logic [2:0] op_mode;
  int n_mismatch = 0, checked = 0, cycles = 0, n;
  always #50 clk = ~clk;
  pmw_core_model core_u (.clk, .halt_exec, .wdt_clear_exec);
  pmw_ctrl #(.RESET_DELAY(RDLY)) dut_u (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m, output int k);
    k = 0;
    while (op_mode !== m && k < 3000) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_run_modes;
    check({lowspeed_xtal_power_sel, power_down_flag}, 2'h0);
    check({hs_clk_en, ls_clk_en}, 2'h3);
    slow_clock_sel = 1'h1;
    repeat (2) @(negedge clk);
    check({hs_clk_en, ls_clk_en, sys_on_slow}, 3'h3);
    xtal_power_wr = 1'h1;
    xtal_power_wdata = 1'h1;
    @(negedge clk) xtal_power_wr = 1'h0;
    @(negedge clk) check({lowspeed_xtal_power_sel, ls_clk_en}, 2'h3);
  endtask
  task automatic t_sleep_port;
    core_u.do_halt();
    check({op_mode, power_down_flag, timeout_flag}, 5'h0a);
    check({hs_clk_en, ls_clk_en, core_run}, 3'h0);
    port_a_pins = 8'hfe;
    repeat (6) @(negedge clk);
    check(op_mode, 3'h2);
    port_a_pins = 8'h7e;
    wait_mode(3'h4, n);
    wait_mode(3'h0, n);
    check(n, 32'h2);
    check(resume, 3'h0);
    port_a_pins = 8'hff;
    repeat (2) @(negedge clk);
    check({hs_clk_en, ls_clk_en}, 2'h1);
    core_u.do_clear();
    check({power_down_flag, wdt_enabled}, 2'h2);
  endtask
  task automatic t_idle_wdt;
    slow_clock_sel = 1'h0;
    lowspeed_xtal_keepalive = 1'h1;
    cfg_osc_is_crystal = 1'h1;
    watchdog_enable_field = 4'h5;
    repeat (2) @(negedge clk);
    check(wdt_enabled, 1'h1);
    core_u.do_halt();
    check({op_mode, ls_clk_en, hs_clk_en}, 5'h06);
    wdt_overflow = 1'h1;
    @(negedge clk) wdt_overflow = 1'h0;
    wait_mode(3'h4, n);
    wait_mode(3'h0, n);
    check(n, 32'h400);
    check({resume, timeout_flag}, 4'hd);
    core_u.do_clear();
    check(power_down_flag, 1'h0);
  endtask
  task automatic t_irq;
    cfg_osc_is_crystal = 1'h0;
    for (int e = 0; e < 3; e++) begin
      irq_enabled = (e != 0);
      stack_full = (e == 2);
      core_u.do_halt();
      irq_request = 1'h1;
      wait_mode(3'h4, n);
      wait_mode(3'h0, n);
      check(resume, {2'h0, e == 1});
      irq_request = 1'h0;
    end
    stack_full = 1'h0;
  endtask
  task automatic t_ext_reset;
    irq_request = 1'h1;
    core_u.do_halt();
    repeat (8) @(negedge clk);
    check(op_mode, 3'h1);
    ext_reset_n_pin = 1'h0;
    wait_mode(3'h3, n);
    check(full_reset, 1'h1);
    ext_reset_n_pin = 1'h1;
    wait_mode(3'h4, n);
    check(n, RDLY);
    wait_mode(3'h0, n);
    check(n, 32'h2);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    t_run_modes();
    t_sleep_port();
    t_idle_wdt();
    t_irq();
    t_ext_reset();
    report_and_stop();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire

// >>> pkg/pmw_pkg.sv
// Purpose: constants and types for the operating-mode and wake-up controller
// Assumes: 10 MHz clk; system-clock counts are taken on this clock
// Notes: reset delay count is a top parameter so simulation can shorten it
package pmw_pkg;

  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RESET_DELAY_TIME_MS = 100;
  localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_TIME_MS * (CLK_HZ / 1000);
  localparam logic [10:0] RC_STARTUP_SHORT = 11'h002;
  localparam logic [10:0] RC_STARTUP_LONG = 11'h400;
  localparam logic [10:0] CRYSTAL_STARTUP_COUNT = 11'h400;
  localparam logic [3:0] WDT_OFF_CODE = 4'ha;
  localparam logic LXT_POWER_SEL_RESET = 1'h0;
  localparam logic [3:0] WDT_ENABLE_RESET = 4'ha;

  typedef enum logic [2:0] {
    PMW_RUN, PMW_IDLE, PMW_SLEEP, PMW_RSTDLY, PMW_START
  } pmw_mode_e;

  // wake reason kept through the start-up delay
  typedef enum logic [1:0] {
    PMW_WK_NONE, PMW_WK_RESET, PMW_WK_PORT, PMW_WK_IRQ
  } pmw_wake_e;

  typedef struct packed {
    logic wdt_wake;
    logic pc_sp_reset;
    logic irq_vector;
  } pmw_resume_s;

  typedef struct packed {
    pmw_mode_e mode;
    pmw_wake_e wake;
    logic wake_wdt;
    logic [22:0] cnt;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_old;
    logic ext_s1;
    logic ext_s2;
    logic power_down_flag;
    logic timeout_flag;
    logic lowspeed_xtal_power_sel;
    logic hs_clk_en;
    logic ls_clk_en;
    logic sys_on_slow;
    logic lowspeed_rc_osc_en;
    logic core_run;
    logic wdt_clear;
    logic wdt_enabled;
    logic irq_blocked;
    pmw_resume_s resume;
    logic full_reset;
  } pmw_state_s;

endpackage

// >>> rtl/pmw_ctrl.sv
// Purpose: operating-mode selection, power-down entry and wake-up sequencing
// Assumes: core gives one-cycle pulses on clk for halt/clear/watchdog events
// Notes: port pins and external reset pin are synchronised by two flops
// How it works
// - crystal power select resets to 0, quick start; writing 1 gives low power
// - crystal runs normally in both power settings; only start-up time differs (here the start-up count is 1024 in both)
// - low-speed rc keeps running in idle or sleep unless configured off
// - outside power-down, slow select 0 runs fast clock, 1 runs crystal only
// - power-down enters idle if keep-alive is 1, sleep with crystal off if 0
// - power-down entry ignores the slow clock select bit
// - fast system clock is stopped in idle and sleep
// - in sleep the core halts and all stored state is left alone
// - entering sleep clears watchdog; it counts only on rc clock
// - power-down sets power-down flag and clears time-out flag
// - wake on external reset, port a falling edge, interrupt, watchdog overflow
// - reset wake does full reset; watchdog wake sets time-out, resets pc and sp
// - power-down flag cleared by power-up or watchdog clear, set by power-down
// - enabled port a pins wake on falling edge and resume after power-down
// - disabled interrupt or full stack wake resumes after power-down instruction
// - enabled interrupt with room on stack takes normal interrupt response
// - an interrupt flag already set before power-down gives no wake-up
// - every wake waits; reset wake adds reset delay before start-up count
// - start-up count is 2 or 1024 clocks for rc, 1024 for crystal
// - with watchdog disabled its instructions do nothing
// - watchdog overflow resets device (here it only wakes from power-down); enable joins option and control field
// - watchdog off only when field is 1010b and option disabled
`timescale 1ns/1ns
`default_nettype none
module pmw_ctrl
  import pmw_pkg::*;
#(
  parameter int unsigned RESET_DELAY = RESET_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_reset_n_pin,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_a_wake_select,
  input wire logic halt_exec,
  input wire logic wdt_clear_exec,
  input wire logic xtal_power_wr,
  input wire logic xtal_power_wdata,
  input wire logic slow_clock_sel,
  input wire logic lowspeed_xtal_keepalive,
  input wire logic [3:0] watchdog_enable_field,
  input wire logic cfg_wdt_enable,
  input wire logic cfg_lowspeed_rc_osc_enable,
  input wire logic cfg_wdt_on_lowspeed_rc_osc,
  input wire logic cfg_osc_is_crystal,
  input wire logic cfg_rc_short_start,
  input wire logic wdt_overflow,
  input wire logic irq_request,
  input wire logic irq_enabled,
  input wire logic stack_full,
  output logic hs_clk_en,
  output logic ls_clk_en,
  output logic sys_on_slow,
  output logic lowspeed_xtal_power_sel,
  output logic lowspeed_rc_osc_en,
  output logic core_run,
  output logic power_down_flag,
  output logic timeout_flag,
  output logic wdt_clear,
  output logic wdt_enabled,
  output logic full_reset,
  output pmw_resume_s resume,
  output logic [2:0] op_mode
);

  pmw_state_s s;
  pmw_state_s next_s;
  logic [7:0] pa_fall;
  logic irq_wake;
  logic [22:0] startup_len;

  // shared by entry paths that arm the start-up counter
  function automatic logic [22:0] start_count(input logic is_xtal, input logic rc_short);
    if (is_xtal) begin
      start_count = {12'h000, CRYSTAL_STARTUP_COUNT};
    end else if (rc_short) begin
      start_count = {12'h000, RC_STARTUP_SHORT};
    end else begin
      start_count = {12'h000, RC_STARTUP_LONG};
    end
  endfunction

  always_comb begin
    pa_fall = s.pa_old & ~s.pa_s2 & port_a_wake_select;
    // a request already pending at power-down cannot wake us
    irq_wake = irq_request & ~s.irq_blocked;
    startup_len = start_count(cfg_osc_is_crystal, cfg_rc_short_start);
  end

  always_comb begin
    next_s = s;
    next_s.pa_s1 = port_a_pins;
    next_s.pa_s2 = s.pa_s1;
    next_s.pa_old = s.pa_s2;
    next_s.ext_s1 = ext_reset_n_pin;
    next_s.ext_s2 = s.ext_s1;
    next_s.wdt_clear = 1'b0;
    next_s.full_reset = 1'b0;
    next_s.resume = '0;
    next_s.wdt_enabled = cfg_wdt_enable | (watchdog_enable_field != WDT_OFF_CODE);
    next_s.lowspeed_rc_osc_en = cfg_lowspeed_rc_osc_enable;
    if (xtal_power_wr) begin
      next_s.lowspeed_xtal_power_sel = xtal_power_wdata;
    end
    // the crystal stays enabled in both power settings
    unique case (s.mode)
      PMW_RUN: begin
        next_s.core_run = 1'b1;
        next_s.ls_clk_en = 1'b1;
        next_s.hs_clk_en = ~slow_clock_sel;
        next_s.sys_on_slow = slow_clock_sel;
        if (wdt_clear_exec && s.wdt_enabled) begin
          next_s.power_down_flag = 1'b0;
          next_s.wdt_clear = 1'b1;
        end
        if (halt_exec) begin
          // slow select is not consulted here
          next_s.mode = lowspeed_xtal_keepalive ? PMW_IDLE : PMW_SLEEP;
          next_s.hs_clk_en = 1'b0;
          next_s.ls_clk_en = lowspeed_xtal_keepalive;
          next_s.core_run = 1'b0;
          next_s.power_down_flag = 1'b1;
          next_s.timeout_flag = 1'b0;
          next_s.wdt_clear = s.wdt_enabled;
          next_s.irq_blocked = irq_request;
        end
      end
      PMW_IDLE, PMW_SLEEP: begin
        next_s.hs_clk_en = 1'b0;
        next_s.core_run = 1'b0;
        if (!s.ext_s2) begin
          next_s.mode = PMW_RSTDLY;
          next_s.wake = PMW_WK_RESET;
          next_s.full_reset = 1'b1;
          next_s.cnt = 23'(RESET_DELAY);
        end else if (wdt_overflow && s.wdt_enabled && (cfg_wdt_on_lowspeed_rc_osc || s.ls_clk_en)) begin
          next_s.mode = PMW_START;
          next_s.wake_wdt = 1'b1;
          next_s.timeout_flag = 1'b1;
          next_s.cnt = startup_len;
        end else if (|pa_fall) begin
          next_s.mode = PMW_START;
          next_s.wake = PMW_WK_PORT;
          next_s.cnt = startup_len;
        end else if (irq_wake) begin
          next_s.mode = PMW_START;
          next_s.wake = PMW_WK_IRQ;
          next_s.cnt = startup_len;
        end
        if (next_s.mode == PMW_START) begin
          next_s.hs_clk_en = ~slow_clock_sel;
          next_s.ls_clk_en = 1'b1;
        end
      end
      PMW_RSTDLY: begin
        if (s.cnt <= 23'h000001) begin
          next_s.mode = PMW_START;
          next_s.cnt = startup_len;
          next_s.hs_clk_en = 1'b1;
          next_s.ls_clk_en = 1'b1;
          next_s.sys_on_slow = 1'b0;
        end else begin
          next_s.cnt = s.cnt - 23'h000001;
        end
      end
      PMW_START: begin
        if (s.cnt <= 23'h000001) begin
          next_s.mode = PMW_RUN;
          next_s.core_run = 1'b1;
          next_s.sys_on_slow = slow_clock_sel;
          next_s.hs_clk_en = ~slow_clock_sel;
          next_s.wake = PMW_WK_NONE;
          next_s.wake_wdt = 1'b0;
          next_s.irq_blocked = 1'b0;
          next_s.resume.wdt_wake = s.wake_wdt;
          next_s.resume.pc_sp_reset = s.wake_wdt;
          next_s.resume.irq_vector = (s.wake == PMW_WK_IRQ) && irq_enabled
                                     && !stack_full;
        end else begin
          next_s.cnt = s.cnt - 23'h000001;
        end
      end
    endcase
    if (s.mode != PMW_RUN && s.mode != PMW_START && !s.ext_s2 && s.mode != PMW_RSTDLY) begin
      next_s.core_run = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= PMW_RUN;
      s.wake <= PMW_WK_NONE;
      s.ext_s1 <= 1'b1;
      s.ext_s2 <= 1'b1;
      s.pa_s1 <= 8'hff;
      s.pa_s2 <= 8'hff;
      s.pa_old <= 8'hff;
      s.lowspeed_xtal_power_sel <= LXT_POWER_SEL_RESET;
      s.hs_clk_en <= 1'b1;
      s.ls_clk_en <= 1'b1;
      s.lowspeed_rc_osc_en <= 1'b1;
      s.core_run <= 1'b0;
      s.wdt_enabled <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hs_clk_en = s.hs_clk_en;
  assign ls_clk_en = s.ls_clk_en;
  assign sys_on_slow = s.sys_on_slow;
  assign lowspeed_xtal_power_sel = s.lowspeed_xtal_power_sel;
  assign lowspeed_rc_osc_en = s.lowspeed_rc_osc_en;
  assign core_run = s.core_run;
  assign power_down_flag = s.power_down_flag;
  assign timeout_flag = s.timeout_flag;
  assign wdt_clear = s.wdt_clear;
  assign wdt_enabled = s.wdt_enabled;
  assign full_reset = s.full_reset;
  assign resume = s.resume;
  assign op_mode = s.mode;

endmodule
`default_nettype wire
